// file: rpg_pkg.sv
// Package for the read parity generator: byte layout, widths and carriers.
// Assumes one system clock; both ports are sampled as synchronous to it.
package rpg_pkg;

	// Width of one port word.
	localparam int unsigned WORD_W  = 36;
	// Width of one byte including its parity position.
	localparam int unsigned BYTE_W  = 9;
	// Number of bytes in one word.
	localparam int unsigned NBYTES  = 4;
	// Position of the parity bit inside a byte.
	localparam int unsigned PAR_POS = 8;
	// Default FIFO depth.
	localparam int unsigned FIFO_DEPTH = 64;
	// Reset value of a data word.
	localparam logic [35:0] WORD_RST = 36'h000000000;
	// Number of entries in the output skid buffer.
	localparam int unsigned SKID_DEPTH = 2;

	// Port control strobes that travel together.
	typedef struct packed {
		logic chip_select_n;   // Active-low chip select.
		logic transfer_gate;   // Transfer enable, active high.
		logic write_not_read;  // High for write, low for read.
		logic mail_sel;        // High selects the mailbox.
		logic parity_gen_sel;  // High enables parity generation on reads.
	} rpg_ctrl_t;

endpackage : rpg_pkg

// file: rpg_reader_model.sv
// Port B host model: synchronous bus logic issuing reads and mail writes.
// Assumes requests from the bench arrive at the rising edge of clk.
`timescale 1ns/1ps
module rpg_reader_model (
	input wire logic           clk,
	input wire logic           rstn,
	input wire logic           go,
	input wire logic           wr,
	input wire logic           mail,
	input wire logic           pg,
	output rpg_pkg::rpg_ctrl_t ctrl_ff
);
	// Selects change only at an edge, so they stand around every load edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= 5'h10; // Deselected in reset.
		end else begin
			ctrl_ff <= {~go, 1'h1, wr, mail, pg};
		end
	end
endmodule : rpg_reader_model

// file: rpg_top.sv
// Read parity generator of a two-port FIFO with two mailboxes.
// Assumes port controls are synchronous to clk and stable around its edges.
`timescale 1ns/1ps

// Summary of operation
// - Generate read parity when port select high
// - Word is four 9-bit bytes, top bit parity
// - Writes store all 36 bits unchanged
// - Parity from low eight bits, odd/even polarity
// - Generated bits replace stored top bits
// - FIFO parity inserted before output register load
// - Mailbox generation shares input checker trees
// - Mailbox generation needs full read-select decode
// - Mailbox contents untouched by generation
// - Error flag held high during generated mailbox read
// - Port B muxes FIFO/mailbox, port A mailbox
module rpg_top #(
	parameter int unsigned DEPTH = rpg_pkg::FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              odd_even_sel,
	input  wire rpg_pkg::rpg_ctrl_t port_a_ctrl,
	input  wire logic [35:0]       port_a_data_in,
	output logic [35:0]            port_a_data_out,
	output logic                   port_a_parity_error_n,
	input  wire rpg_pkg::rpg_ctrl_t port_b_ctrl,
	input  wire logic [35:0]       port_b_data_in,
	output logic [35:0]            port_b_data_out,
	output logic                   port_b_parity_error_n,
	output logic                   port_b_out_valid,
	output logic                   fifo_full,
	output logic                   fifo_empty
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode and shared parity trees.

	localparam int unsigned AW = $clog2(DEPTH);

	// Operation decodes for each port.
	logic sel_a;
	logic sel_b;
	logic fifo_wr;
	logic fifo_rd_req;
	logic mail_wr_a;
	logic mail_wr_b;
	logic gen_mail_a;
	logic gen_mail_b;

	always_comb begin
		sel_a       = !port_a_ctrl.chip_select_n && port_a_ctrl.transfer_gate;
		sel_b       = !port_b_ctrl.chip_select_n && port_b_ctrl.transfer_gate;
		fifo_wr     = sel_a && port_a_ctrl.write_not_read && !port_a_ctrl.mail_sel;
		fifo_rd_req = sel_b && !port_b_ctrl.write_not_read && !port_b_ctrl.mail_sel;
		mail_wr_a   = sel_a && port_a_ctrl.write_not_read && port_a_ctrl.mail_sel;
		mail_wr_b   = sel_b && port_b_ctrl.write_not_read && port_b_ctrl.mail_sel;
		gen_mail_a  = sel_a && !port_a_ctrl.write_not_read && port_a_ctrl.mail_sel
			&& port_a_ctrl.parity_gen_sel;
		gen_mail_b  = sel_b && !port_b_ctrl.write_not_read && port_b_ctrl.mail_sel
			&& port_b_ctrl.parity_gen_sel;
	end

	// Stored words.
	logic [35:0] mailbox_a_to_b_ff;
	logic [35:0] mailbox_b_to_a_ff;
	logic [35:0] fifo_mem [DEPTH];

	// Tree inputs: a port's tree checks its input bus or, while generating, its mailbox.
	logic [35:0] tree_a_in;
	logic [35:0] tree_b_in;
	logic [35:0] sub_a;
	logic [35:0] sub_b;
	logic [35:0] sub_fifo;
	logic [3:0]  err_a;
	logic [3:0]  err_b;
	logic [35:0] fifo_raw;

	always_comb begin
		tree_a_in = gen_mail_a ? mailbox_b_to_a_ff : port_a_data_in;
		tree_b_in = gen_mail_b ? mailbox_a_to_b_ff : port_b_data_in;
	end

	// Per byte: generated bit makes the nine-bit ones count match the polarity.
	for (genvar i = 0; i < rpg_pkg::NBYTES; i++) begin : g_byte
		localparam int unsigned LO = i * rpg_pkg::BYTE_W;
		localparam int unsigned HI = LO + rpg_pkg::PAR_POS;
		logic pa;
		logic pb;
		logic pf;
		// Even parity of the low eight bits, folded with the odd/even select.
		assign pa = ^tree_a_in[HI-1:LO] ^ odd_even_sel;
		assign pb = ^tree_b_in[HI-1:LO] ^ odd_even_sel;
		assign pf = ^fifo_raw[HI-1:LO] ^ odd_even_sel;
		// Checker: a byte errs when its nine-bit count breaks the polarity.
		assign err_a[i] = pa ^ tree_a_in[HI];
		assign err_b[i] = pb ^ tree_b_in[HI];
		// Substitution into the top bit of each byte.
		assign sub_a[HI:LO] = {pa, tree_a_in[HI-1:LO]};
		assign sub_b[HI:LO] = {pb, tree_b_in[HI-1:LO]};
		assign sub_fifo[HI:LO] = port_b_ctrl.parity_gen_sel ?
			{pf, fifo_raw[HI-1:LO]} : fifo_raw[HI:LO];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mailboxes: written whole, never altered by generation.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mailbox_a_to_b_ff <= rpg_pkg::WORD_RST;
		end else if (mail_wr_a) begin
			mailbox_a_to_b_ff <= port_a_data_in;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mailbox_b_to_a_ff <= rpg_pkg::WORD_RST;
		end else if (mail_wr_b) begin
			mailbox_b_to_a_ff <= port_b_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// FIFO array and pointers.

	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;
	logic        mem_empty;
	logic        mem_full;
	logic        skid_ready;
	logic        pop;

	always_comb begin
		mem_empty = (wr_ptr_ff == rd_ptr_ff);
		mem_full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
		fifo_raw  = fifo_mem[rd_ptr_ff[AW-1:0]];
		pop       = !mem_empty && skid_ready;
	end

	// Array write stores every input bit as applied.
	always_ff @(posedge clk) begin
		if (fifo_wr && !mem_full) begin
			fifo_mem[wr_ptr_ff[AW-1:0]] <= port_a_data_in;
		end
	end

	// Write pointer.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_ff <= '0;
		end else if (fifo_wr && !mem_full) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	// Read pointer advances whenever the skid buffer accepts a word.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ptr_ff <= '0;
		end else if (pop) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer between array and output register, loaded with parity applied.

	logic [35:0] skid_mem_ff [rpg_pkg::SKID_DEPTH];
	logic        skid_wp_ff;
	logic        skid_rp_ff;
	logic [1:0]  skid_cnt_ff;
	logic        skid_pop;

	always_comb begin
		skid_ready = (skid_cnt_ff != 2'(rpg_pkg::SKID_DEPTH));
		skid_pop   = (skid_cnt_ff != 2'h0) && fifo_rd_req;
	end

	// Storage of the skid buffer; the word is already substituted.
	always_ff @(posedge clk) begin
		if (pop) begin
			skid_mem_ff[skid_wp_ff] <= sub_fifo;
		end
	end

	// Skid pointers and occupancy.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			skid_wp_ff  <= 1'b0;
			skid_rp_ff  <= 1'b0;
			skid_cnt_ff <= 2'h0;
		end else begin
			skid_wp_ff  <= skid_wp_ff ^ pop;
			skid_rp_ff  <= skid_rp_ff ^ skid_pop;
			skid_cnt_ff <= skid_cnt_ff + 2'(pop) - 2'(skid_pop);
		end
	end

	// FIFO output register, loaded by a port-B FIFO read.
	logic [35:0] fifo_out_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fifo_out_ff      <= rpg_pkg::WORD_RST;
			port_b_out_valid <= 1'b0;
		end else begin
			if (skid_pop) begin
				fifo_out_ff <= skid_mem_ff[skid_rp_ff];
			end
			port_b_out_valid <= skid_pop;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered port outputs.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_a_data_out       <= rpg_pkg::WORD_RST;
			port_b_data_out       <= rpg_pkg::WORD_RST;
			port_a_parity_error_n <= 1'b1;
			port_b_parity_error_n <= 1'b1;
			fifo_full             <= 1'b0;
			fifo_empty            <= 1'b1;
		end else begin
			// Port A always shows mailbox B-to-A, substituted when generating.
			port_a_data_out <= gen_mail_a ? sub_a : mailbox_b_to_a_ff;
			// Port B shows mailbox A-to-B when mail select high, else FIFO register.
			if (port_b_ctrl.mail_sel) begin
				port_b_data_out <= gen_mail_b ? sub_b : mailbox_a_to_b_ff;
			end else if (skid_pop) begin
				port_b_data_out <= skid_mem_ff[skid_rp_ff];
			end else begin
				port_b_data_out <= fifo_out_ff;
			end
			// Error flags forced high while the tree generates mailbox parity.
			port_a_parity_error_n <= gen_mail_a ? 1'b1 : !(|err_a);
			port_b_parity_error_n <= gen_mail_b ? 1'b1 : !(|err_b);
			fifo_full             <= mem_full;
			fifo_empty            <= mem_empty && (skid_cnt_ff == 2'h0);
		end
	end

endmodule : rpg_top

// file: rpg_top_monitor.sv
// Port checker for the read parity generator.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module rpg_top_monitor #(
	parameter int unsigned DEPTH = 64
) (
	input wire logic               clk,
	input wire logic               rstn,
	input wire logic               odd_even_sel,
	input wire rpg_pkg::rpg_ctrl_t port_a_ctrl,
	input wire logic [35:0]        port_a_data_in,
	input wire logic [35:0]        port_a_data_out,
	input wire logic               port_a_parity_error_n,
	input wire rpg_pkg::rpg_ctrl_t port_b_ctrl,
	input wire logic [35:0]        port_b_data_in,
	input wire logic [35:0]        port_b_data_out,
	input wire logic               port_b_parity_error_n,
	input wire logic               port_b_out_valid,
	input wire logic               fifo_full,
	input wire logic               fifo_empty
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Generated mailbox reads, FIFO reads and port B mailbox writes.
	wire logic gen_a = port_a_ctrl == 5'h0B;
	wire logic gen_b = port_b_ctrl == 5'h0B;
	wire logic rd_b  = port_b_ctrl[4:1] == 4'h4;
	wire logic wm_b  = port_b_ctrl[4:1] == 4'h7;
	// True when every byte holds the ones count that o asks for.
	function automatic logic par_ok(logic [35:0] w, logic o);
		return (^w[8:0] == o) && (^w[17:9] == o) && (^w[26:18] == o) && (^w[35:27] == o);
	endfunction : par_ok
	// Cycles in which the matching port's output may not change.
	sequence quiet_a; !gen_a && !wm_b; endsequence
	sequence quiet_b; !port_b_ctrl.mail_sel && !rd_b; endsequence
	////////////////////////////////////////////////////////////////////////////////
	err_hold_a_a: assert property (gen_a |=> port_a_parity_error_n)
		else $error("port A flag low in generated read");
	err_hold_b_a: assert property (gen_b |=> port_b_parity_error_n)
		else $error("port B flag low in generated read");
	gen_par_a_a: assert property (gen_a |=> par_ok(port_a_data_out, $past(odd_even_sel)))
		else $error("port A generated parity wrong");
	gen_par_b_a: assert property (gen_b |=> par_ok(port_b_data_out, $past(odd_even_sel)))
		else $error("port B generated parity wrong");
	empty_read_a: assert property (rd_b && fifo_empty |=> !port_b_out_valid)
		else $error("word loaded from empty FIFO");
	valid_cause_a: assert property (port_b_out_valid |-> $past(rd_b) && !$past(fifo_empty))
		else $error("load without a read");
	mbox_hold_a: assert property (quiet_a ##1 quiet_a |=> $stable(port_a_data_out))
		else $error("port A word changed");
	fifo_hold_a: assert property (quiet_b ##1 quiet_b |=> $stable(port_b_data_out))
		else $error("port B word changed");
endmodule : rpg_top_monitor
bind rpg_top rpg_top_monitor #(.DEPTH(DEPTH)) mon_u (.*);

// file: tb_read_parity_generator.sv
// Self-checking bench for the read parity generator.
// Assumes a short FIFO and the port B host model.
`timescale 1ns/1ps
module tb_read_parity_generator;
	localparam int unsigned DEPTH = 4; // Short FIFO keeps fills brief.
	logic               clk, rstn, odd_even_sel, go, wr, mail, pg, port_b_out_valid;
	logic               port_a_parity_error_n, port_b_parity_error_n, fifo_full, fifo_empty;
	rpg_pkg::rpg_ctrl_t port_a_ctrl, port_b_ctrl;
	logic [35:0]        port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out, w, v, u;
	logic [31:0]        seed = 32'h8310;
	logic [35:0]        q[$];
	int                 miscompares = 0, num_checks = 0;
	rpg_top #(.DEPTH(DEPTH)) dut_u (.*);
	rpg_reader_model part_u (.clk(clk), .rstn(rstn), .go(go), .wr(wr), .mail(mail), .pg(pg),
		.ctrl_ff(port_b_ctrl));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Xorshift source and a 36-bit word drawn from it.
	function automatic logic [35:0] rnd();
		logic [63:0] r;
		for (int i = 0; i < 2; i++) begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			r = {r[31:0], seed};
		end
		return r[35:0];
	endfunction : rnd
	// Word as read: top bit of each byte replaced when g is set.
	function automatic logic [35:0] exp_word(logic [35:0] d, logic o, logic g);
		for (int i = 0; i < 4; i++) begin
			if (g) d[9*i+8] = ^d[9*i+:8] ^ o;
		end
		return d;
	endfunction : exp_word
	task automatic chk(logic [35:0] seen, logic [35:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	initial begin
		{rstn, odd_even_sel, go, wr, mail, pg} = 6'h0;
		{port_a_ctrl, port_a_data_in, port_b_data_in} = {5'h10, 72'h0};
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		// Fill past full, then drain with a stalling reader, for every select pair.
		for (int k = 0; k < 4; k++) begin
			{odd_even_sel, pg} <= {k[0], k[1]};
			// Eight writes into array plus buffer with the reader idle: the last two are refused.
			for (int t = 0; t < 8; t++) begin
				@(posedge clk);
				w = (t == 0) ? 36'h0 : (t == 1) ? 36'hFFFFFFFFF : rnd(); // Corner words first.
				port_a_data_in <= w;
				port_a_ctrl <= {4'h6, w[0]};
				if (t < DEPTH + rpg_pkg::SKID_DEPTH) q.push_back(exp_word(w, k[0], k[1]));
			end
			@(posedge clk);
			port_a_ctrl <= 5'h10;
			@(negedge clk);
			chk({35'h0, fifo_full}, 36'h1);
			@(posedge clk);
			for (int t = 0; t < 300 && q.size() > 0; t++) begin
				v = rnd();
				go <= v[0];
				@(negedge clk);
				if (port_b_out_valid === 1'h1) chk(port_b_data_out, q.pop_front());
				@(posedge clk);
			end
			if (q.size() > 0) begin
				miscompares++;
				conclude();
			end
			repeat (4) begin
				go <= 1'h1;
				@(negedge clk);
				chk({33'h0, port_b_out_valid, fifo_empty, fifo_full}, 36'h2);
				@(posedge clk);
			end
			go <= 1'h0;
		end
		// Mail both ways, then read with and without generation.
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			{w, v} = {rnd(), rnd()};
			{port_a_data_in, port_b_data_in} <= {w, v};
			port_a_ctrl <= 5'h0E;
			{go, wr, mail, pg, odd_even_sel} <= {4'hE, k[0]};
			repeat (3) @(posedge clk);
			for (int g = 1; g >= 0; g--) begin
				port_a_ctrl <= {4'h5, g[0]};
				{wr, pg} <= {1'h0, g[0]};
				u = rnd();
				// Port B keeps v: on the g == 1 pass its host model still writes mail at the next edge.
				port_a_data_in <= u;
				repeat (3) @(posedge clk);
				@(negedge clk);
				chk(port_a_data_out, exp_word(v, k[0], g[0]));
				chk(port_b_data_out, exp_word(w, k[0], g[0]));
				if (g == 1) chk({34'h0, port_a_parity_error_n, port_b_parity_error_n}, 36'h3);
				else chk({34'h0, port_a_parity_error_n, port_b_parity_error_n},
					{34'h0, exp_word(u, k[0], 1'h1) === u, exp_word(v, k[0], 1'h1) === v});
				@(posedge clk);
			end
		end
		conclude();
	end
endmodule : tb_read_parity_generator
